// ===== tctu_pkg.sv
// package for the three-channel timer unit: register offsets, field
// positions, reset values and cycle counts.
// assumes a 16-bit timer datapath behind a 32-bit avalon-mm slave.
package tctu_pkg;
   localparam int unsigned DW = 16;
   // timer event service: each timer gets one slot every fourth cycle
   localparam logic [1:0] SLOTS = 2'h3;
   // byte offsets: the eleven 16-bit timer registers, then own extras
   localparam logic [7:0] OFS_CNT0   = 8'h00;
   localparam logic [7:0] OFS_MAXA0  = 8'h04;
   localparam logic [7:0] OFS_MAXB0  = 8'h08;
   localparam logic [7:0] OFS_CTL0   = 8'h0c;
   localparam logic [7:0] OFS_CNT1   = 8'h10;
   localparam logic [7:0] OFS_MAXA1  = 8'h14;
   localparam logic [7:0] OFS_MAXB1  = 8'h18;
   localparam logic [7:0] OFS_CTL1   = 8'h1c;
   localparam logic [7:0] OFS_CNT2   = 8'h20;
   localparam logic [7:0] OFS_MAXA2  = 8'h24;
   localparam logic [7:0] OFS_CTL2   = 8'h2c;
   localparam logic [7:0] OFS_ISTAT  = 8'h30;
   localparam logic [7:0] OFS_IMASK  = 8'h34;
   // control register fields
   localparam int unsigned CTL_EN    = 0;  // timer runs
   localparam int unsigned CTL_ALT   = 1;  // use both max-count registers
   localparam int unsigned CTL_EXT   = 2;  // count rising edges of input pin
   localparam int unsigned CTL_PRE   = 3;  // count timer two wraps
   localparam int unsigned CTL_CONT  = 4;  // keep running after terminal count
   localparam int unsigned CTL_WDOG  = 5;  // timer one output feeds watchdog irq
   localparam int unsigned CTL_GATE  = 6;  // internal count only while input high
   localparam int unsigned CTL_RIU   = 12; // read-only: max b in control
   localparam logic [15:0] CTL_RST   = 16'h0000;
   localparam logic [15:0] MAX_RST   = 16'h0000;
   // interrupt status bits
   localparam int unsigned IRQ_TC0   = 0;
   localparam int unsigned IRQ_TC1   = 1;
   localparam int unsigned IRQ_TC2   = 2;
   localparam int unsigned IRQ_WDOG  = 3;
   localparam int unsigned NIRQ      = 4;
   // output response from pin change: two sync + edge + slot wait + out flop
   localparam int unsigned RESP_CYC  = 6;
endpackage

// ===== tctu_ch_if.sv
// interface carrying one timer channel's controls and results.
// assumes the top drives controls and reads results on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface tctu_ch_if;
   logic [15:0] cnt_wdata;
   logic        cnt_we;
   logic [15:0] max_a;
   logic [15:0] max_b;
   logic [15:0] ctl;
   logic        tick;
   logic        gate;
   logic        slot;
   logic [15:0] count;
   logic        use_b;
   logic        term;
   logic        out_lvl;
   modport ctrl (output cnt_wdata, cnt_we, max_a, max_b, ctl, tick, gate, slot,
                 input  count, use_b, term, out_lvl);
   modport chan (input  cnt_wdata, cnt_we, max_a, max_b, ctl, tick, gate, slot,
                 output count, use_b, term, out_lvl);
endinterface
`default_nettype wire

// ===== tctu_chan.sv
// one 16-bit timer channel: count, dual maximum, output level.
// assumes tick is a one-cycle event and slot marks its service cycle.
`timescale 1ns/1ns
`default_nettype none
module tctu_chan (
   input  wire logic ref_clk,    // clock
   input  wire logic srst,       // sync reset
   input  wire logic ce,         // clock enable
   tctu_ch_if.chan   ch          // channel link
);
   logic [15:0] count;
   logic [15:0] next_count;
   logic        use_b;
   logic        next_use_b;
   logic        term;
   logic        next_term;
   logic        out_lvl;
   logic        next_out_lvl;
   logic        pend;
   logic        next_pend;
   logic        run;
   logic        next_run;
   logic [15:0] lim;
   logic [15:0] inc;

   always_comb begin
      next_count   = count;
      next_use_b   = use_b;
      next_term    = 1'b0;
      next_pend    = pend;
      next_run     = run;
      lim          = (ch.ctl[tctu_pkg::CTL_ALT] && use_b) ? ch.max_b : ch.max_a;
      inc          = count + 16'h0001;
      if (!ch.ctl[tctu_pkg::CTL_EN]) begin
         next_run = 1'b1;
      end
      // edge events between slots are held until this timer's service cycle;
      // the internal clock is its own slot, so holding it would add a count
      if (ch.tick && ch.gate && ch.ctl[tctu_pkg::CTL_EN] && run
          && (ch.ctl[tctu_pkg::CTL_EXT] || ch.ctl[tctu_pkg::CTL_PRE])) begin
         next_pend = 1'b1;
      end
      if (ch.slot && (pend || (ch.tick && ch.gate)) && ch.ctl[tctu_pkg::CTL_EN] && run) begin
         next_pend = 1'b0;
         if (inc == lim) begin
            next_count = 16'h0000;
            next_term  = 1'b1;
            if (ch.ctl[tctu_pkg::CTL_ALT]) begin
               next_use_b = ~use_b;
            end
            if (!ch.ctl[tctu_pkg::CTL_CONT] && (!ch.ctl[tctu_pkg::CTL_ALT] || use_b)) begin
               next_run = 1'b0;
            end
         end else begin
            next_count = inc;
         end
      end
      if (ch.cnt_we) begin
         next_count = ch.cnt_wdata;
      end
      if (ch.ctl[tctu_pkg::CTL_ALT]) begin
         next_out_lvl = ~next_use_b;
      end else begin
         next_out_lvl = ~next_term;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         count   <= 16'h0000;
         use_b   <= 1'b0;
         term    <= 1'b0;
         out_lvl <= 1'b1;
         pend    <= 1'b0;
         run     <= 1'b1;
      end else if (ce) begin
         count   <= next_count;
         use_b   <= next_use_b;
         term    <= next_term;
         out_lvl <= next_out_lvl;
         pend    <= next_pend;
         run     <= next_run;
      end
   end

   assign ch.count   = count;
   assign ch.use_b   = use_b;
   assign ch.term    = term;
   assign ch.out_lvl = out_lvl;
endmodule
`default_nettype wire

// ===== tctu_top.sv
// three-channel timer unit with avalon-mm register slave.
// assumes timer input pins are asynchronous and toggle at most at
// a quarter of ref_clk; bus master is on ref_clk.
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module tctu_top (
   input  wire logic        ref_clk,           // 100 mhz clock
   input  wire logic        srst,              // sync reset, high
   input  wire logic        clk_en,            // freezes all state when low
   input  wire logic [7:0]  avs_address,       // byte address
   input  wire logic        avs_read,          // read request
   input  wire logic        avs_write,         // write request
   input  wire logic [31:0] avs_writedata,     // write data
   input  wire logic [3:0]  avs_byteenable,    // byte lanes
   output logic [31:0]      avs_readdata,      // read data
   output logic             avs_waitrequest,   // stall
   output logic [1:0]       avs_response,      // 00 ok, 10 slave error
   input  wire logic        timer_zero_input,  // async pin
   input  wire logic        timer_one_input,   // async pin
   output logic             timer_zero_output, // pin
   output logic             timer_one_output,  // pin
   output logic             dma_req_t2,        // timer two dma request pulse
   output logic             irq                // level interrupt
);
   tctu_ch_if chif[3] ();

   logic [15:0] max_a     [3];
   logic [15:0] next_max_a[3];
   logic [15:0] max_b     [2];
   logic [15:0] next_max_b[2];
   logic [15:0] ctl       [3];
   logic [15:0] next_ctl  [3];
   localparam int unsigned NI = tctu_pkg::NIRQ;
   logic [NI-1:0] istat;
   logic [NI-1:0] next_istat;
   logic [NI-1:0] imask;
   logic [NI-1:0] next_imask;

   logic [1:0]  sync_a [2];
   logic [1:0]  prev_in;
   logic [1:0]  slot;
   logic        bus_ack;
   logic        next_bus_ack;
   logic [31:0] next_rdata;
   logic [1:0]  next_resp;
   logic [1:0]  out_q;
   logic        dma_q;
   logic        irq_q;
   logic [2:0]  cnt_we;
   logic        t2_wrap;
   logic [1:0]  pin_in;
   // channel results in plain arrays: interface arrays take constant indices only
   logic [15:0] cnt_of [3];
   logic [2:0]  term_of;
   logic [2:0]  useb_of;
   logic        wait_q;

   // selects the timer a byte address hits, or 3 for none
   function automatic logic [1:0] tmr_of(input logic [7:0] a);
      tmr_of = (a < tctu_pkg::OFS_ISTAT) ? a[5:4] : 2'h3;
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // two sync flops and one edge flop per pin; the first is read only by the second
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sync_a[0] <= 2'h0;
         sync_a[1] <= 2'h0;
         prev_in   <= 2'h0;
      end else if (clk_en) begin
         sync_a[0] <= {timer_one_input, timer_zero_input};
         sync_a[1] <= sync_a[0];
         prev_in   <= sync_a[1];
      end
   end
   assign pin_in = sync_a[1];

   // round-robin slot: timer i serviced when slot == i, slot 3 idle
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         slot <= 2'h0;
      end else if (clk_en) begin
         slot <= (slot == tctu_pkg::SLOTS) ? 2'h0 : slot + 2'h1;
      end
   end

   assign t2_wrap = chif[2].term;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_ch
         if (gi < 2) begin : g_pin
            always_comb begin
               if (ctl[gi][tctu_pkg::CTL_EXT]) begin
                  chif[gi].tick = pin_in[gi] & ~prev_in[gi];
                  chif[gi].gate = 1'b1;
               end else if (ctl[gi][tctu_pkg::CTL_PRE]) begin
                  chif[gi].tick = t2_wrap;
                  chif[gi].gate = 1'b1;
               end else begin
                  chif[gi].tick = 1'b1;
                  chif[gi].gate = ~ctl[gi][tctu_pkg::CTL_GATE] | pin_in[gi];
               end
            end
            assign chif[gi].max_b = max_b[gi];
         end else begin : g_nopin
            assign chif[gi].tick  = 1'b1;
            assign chif[gi].gate  = 1'b1;
            assign chif[gi].max_b = max_a[gi];
         end
         assign chif[gi].cnt_wdata = avs_writedata[15:0];
         assign chif[gi].cnt_we    = cnt_we[gi];
         assign chif[gi].max_a     = max_a[gi];
         // timer two has no pins and no prescaler: alt, ext and pre bits ignored
         assign chif[gi].ctl       = (gi < 2) ? ctl[gi] : (ctl[gi] & 16'hfff1);
         assign chif[gi].slot      = (slot == 2'(gi));
         assign cnt_of[gi]         = chif[gi].count;
         assign term_of[gi]        = chif[gi].term;
         assign useb_of[gi]        = chif[gi].use_b;
         tctu_chan u_ch (
            .ref_clk (ref_clk),
            .srst    (srst),
            .ce      (clk_en),
            .ch      (chif[gi])
         );
      end
   endgenerate

   logic        req;
   logic [1:0]  tsel;
   logic [15:0] wmask;
   assign req   = (avs_read | avs_write) & ~bus_ack;
   assign tsel  = tmr_of(avs_address);
   assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   always_comb begin
      cnt_we = 3'h0;
      if (req && avs_write && clk_en) begin
         for (int i = 0; i < 3; i++) begin
            if (hit(avs_address, 8'(tctu_pkg::OFS_CNT0 + 8'(i * 16)))) begin
               cnt_we[i] = 1'b1;
            end
         end
      end
   end

   // register file and bus answer: one wait cycle, answer on second edge
   always_comb begin
      next_max_a   = max_a;
      next_max_b   = max_b;
      next_ctl     = ctl;
      next_imask   = imask;
      next_bus_ack = req;
      next_rdata   = 32'h0000_0000;
      next_resp    = 2'h0;
      next_istat   = istat;
      if (req && avs_write) begin
         for (int i = 0; i < 3; i++) begin
            if (hit(avs_address, 8'(tctu_pkg::OFS_MAXA0 + 8'(i * 16)))) begin
               next_max_a[i] = (max_a[i] & ~wmask) | (avs_writedata[15:0] & wmask);
            end
            if (hit(avs_address, 8'(tctu_pkg::OFS_CTL0 + 8'(i * 16)))) begin
               next_ctl[i] = (ctl[i] & ~wmask) | (avs_writedata[15:0] & wmask);
            end
         end
         for (int i = 0; i < 2; i++) begin
            if (hit(avs_address, 8'(tctu_pkg::OFS_MAXB0 + 8'(i * 16)))) begin
               next_max_b[i] = (max_b[i] & ~wmask) | (avs_writedata[15:0] & wmask);
            end
         end
         if (hit(avs_address, tctu_pkg::OFS_ISTAT) && avs_byteenable[0]) begin
            next_istat = istat & ~avs_writedata[NI-1:0];
         end
         if (hit(avs_address, tctu_pkg::OFS_IMASK) && avs_byteenable[0]) begin
            next_imask = avs_writedata[NI-1:0];
         end
      end
      if (req) begin
         if (tsel != 2'h3) begin
            unique case (avs_address[3:0])
               4'h0: next_rdata = {16'h0000, cnt_of[tsel]};
               4'h4: next_rdata = {16'h0000, max_a[tsel]};
               4'h8: next_rdata = (tsel < 2'h2) ? {16'h0000, max_b[tsel[0]]} : 32'h0;
               4'hc: begin
                  next_rdata = {16'h0000, ctl[tsel]};
                  next_rdata[tctu_pkg::CTL_RIU] = useb_of[tsel];
               end
               default: next_resp = 2'h2;
            endcase
            if (tsel == 2'h2 && avs_address[3:0] == 4'h8) begin
               next_resp = 2'h2;
            end
         end else if (hit(avs_address, tctu_pkg::OFS_ISTAT)) begin
            next_rdata = {28'h0, istat};
         end else if (hit(avs_address, tctu_pkg::OFS_IMASK)) begin
            next_rdata = {28'h0, imask};
         end else begin
            next_resp = 2'h2;
         end
      end
      // hardware set wins over a same-cycle clear
      for (int i = 0; i < 3; i++) begin
         if (term_of[i]) begin
            next_istat[i] = 1'b1;
         end
      end
      if (ctl[1][tctu_pkg::CTL_WDOG] && !chif[1].out_lvl) begin
         next_istat[tctu_pkg::IRQ_WDOG] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int i = 0; i < 3; i++) begin
            max_a[i] <= tctu_pkg::MAX_RST;
            ctl[i]   <= tctu_pkg::CTL_RST;
         end
         max_b[0]     <= tctu_pkg::MAX_RST;
         max_b[1]     <= tctu_pkg::MAX_RST;
         istat        <= '0;
         imask        <= '0;
         bus_ack      <= 1'b0;
         wait_q       <= 1'b1;
         avs_readdata <= 32'h0000_0000;
         avs_response <= 2'h0;
         out_q        <= 2'h3;
         dma_q        <= 1'b0;
         irq_q        <= 1'b0;
      end else if (clk_en) begin
         max_a        <= next_max_a;
         max_b        <= next_max_b;
         ctl          <= next_ctl;
         istat        <= next_istat;
         imask        <= next_imask;
         bus_ack      <= next_bus_ack;
         wait_q       <= ~next_bus_ack;
         avs_readdata <= next_rdata;
         avs_response <= next_resp;
         out_q        <= {chif[1].out_lvl, chif[0].out_lvl};
         dma_q        <= t2_wrap;
         irq_q        <= |(next_istat & imask);
      end
   end

   always_comb begin
      avs_waitrequest   = wait_q;
      timer_zero_output = out_q[0];
      timer_one_output  = out_q[1];
      dma_req_t2        = dma_q;
      irq               = irq_q;
   end
endmodule
`default_nettype wire

// ===== tctu_monitor.sv
// checker for the timer unit's bus, pulse and interrupt ports.
// assumes clk_en drops only while the bus is idle; freezing stretches figures.
`timescale 1ns/1ns
`default_nettype none
module tctu_monitor (
   input wire logic        ref_clk,           // clock
   input wire logic        srst,              // sync reset
   input wire logic [7:0]  avs_address,       // byte address
   input wire logic        avs_read,          // read request
   input wire logic        avs_write,         // write request
   input wire logic [31:0] avs_readdata,      // read data
   input wire logic        avs_waitrequest,   // stall
   input wire logic [1:0]  avs_response,      // response code
   input wire logic        timer_zero_output, // pin
   input wire logic        dma_req_t2,        // dma pulse
   input wire logic        irq                // interrupt
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   function automatic logic mapped(input logic [7:0] a);
      return a[1:0] == 2'h0 && a <= tctu_pkg::OFS_IMASK && a != 8'h28;
   endfunction
   property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("answer held too long");
   property p_cause; !avs_waitrequest |-> $past(avs_read) || $past(avs_write); endproperty
   a_cause: assert property (p_cause) else $error("answer without request");
   property p_idle; !avs_read && !avs_write |=> avs_waitrequest; endproperty
   a_idle: assert property (p_idle) else $error("answer while idle");
   property p_resp;
      !avs_waitrequest |-> avs_response == (mapped(avs_address) ? 2'h0 : 2'h2);
   endproperty
   a_resp: assert property (p_resp) else $error("wrong response code");
   property p_upper; !avs_waitrequest && avs_read |-> avs_readdata[31:16] == 16'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper read half set");
   property p_dma_gap; dma_req_t2 |=> !dma_req_t2 [*3]; endproperty
   a_dma_gap: assert property (p_dma_gap) else $error("timer two wraps too close");
   property p_out_gap;
      $fell(timer_zero_output) |=> !$fell(timer_zero_output) [*3];
   endproperty
   a_out_gap: assert property (p_out_gap) else $error("timer zero output too fast");
   property p_irq_fall;
      $fell(irq) |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
   c_read: cover property (avs_read && !avs_waitrequest);
   c_irq: cover property ($rose(irq));
   c_dma: cover property (dma_req_t2);
   c_out0: cover property ($fell(timer_zero_output));
endmodule
bind tctu_top tctu_monitor u_mon (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
   .timer_zero_output(timer_zero_output), .dma_req_t2(dma_req_t2), .irq(irq));
`default_nettype wire

// ===== tctu_pin_src.sv
// external event source driving the two timer input pins.
// assumes pulses() is called right after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module tctu_pin_src (
   input  wire logic ref_clk, // clock
   output logic      pin0,    // timer zero input
   output logic      pin1     // timer one input
);
   initial begin
      pin0 = 1'b0;
      pin1 = 1'b0;
   end
   // half of two or more keeps the pin at a quarter rate at most
   task automatic pulses(input int sel, input int n, input int half);
      for (int k = 0; k < 2 * n; k++) begin
         if (sel == 0) pin0 <= ~pin0;
         else pin1 <= ~pin1;
         repeat (half) @(posedge ref_clk);
      end
   endtask
endmodule
`default_nettype wire

// ===== three_channel_timer_unit_test.sv
// bench for the timer unit: bus tasks, pin pulses, pulse and run monitors.
// assumes the pin source model and the checker bind are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module three_channel_timer_unit_test;
   localparam logic [15:0] ALT = 16'h1 << tctu_pkg::CTL_ALT;
   localparam logic [15:0] EXT = 16'h1 << tctu_pkg::CTL_EXT;
   localparam logic [15:0] PRE = 16'h1 << tctu_pkg::CTL_PRE;
   localparam logic [15:0] WDG = 16'h1 << tctu_pkg::CTL_WDOG;
   localparam logic [15:0] GTE = 16'h1 << tctu_pkg::CTL_GATE;
   localparam logic [15:0] RUN = (16'h1 << tctu_pkg::CTL_EN) | (16'h1 << tctu_pkg::CTL_CONT);
   logic        ref_clk, srst = 1'b1, rq_rd = 1'b0, rq_wr = 1'b0, ce = 1'b1;
   logic [7:0]  adr = 8'h0;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [1:0]  resp, rsp;
   logic        stall, pin0, pin1, out0, out1, dma, irq, prev1, pp0, po0;
   int          mismatches = 0, samples_checked = 0, cyc = 0, n_lo0 = 0, n_dma = 0;
   int          run = 0, run_hi = 0, run_lo = 0, rise_c = 0, lat = 0, dma_c = 0, gap = 0;
   int          a, b, n, h, base;
   logic [7:0]  probe [3] = '{8'h28, 8'h38, tctu_pkg::OFS_ISTAT};
   logic [7:0]  rw [4] = '{tctu_pkg::OFS_MAXA0, tctu_pkg::OFS_MAXB0,
                           tctu_pkg::OFS_MAXA2, tctu_pkg::OFS_CNT1};
   tctu_top DUT (.ref_clk(ref_clk), .srst(srst), .clk_en(ce), .avs_address(adr),
      .avs_read(rq_rd), .avs_write(rq_wr), .avs_writedata(wdat), .avs_byteenable(4'hf),
      .avs_readdata(rdat), .avs_waitrequest(stall), .avs_response(resp),
      .timer_zero_input(pin0), .timer_one_input(pin1), .timer_zero_output(out0),
      .timer_one_output(out1), .dma_req_t2(dma), .irq(irq));
   tctu_pin_src u_src (.ref_clk(ref_clk), .pin0(pin0), .pin1(pin1));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // run lengths of timer one output, spacing of wraps, pin-to-output delay
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      prev1 <= out1;
      pp0 <= pin0;
      po0 <= out0;
      if (out0 === 1'b0) n_lo0 <= n_lo0 + 1;
      if (pin0 === 1'b1 && pp0 === 1'b0) rise_c <= cyc;
      if (out0 === 1'b0 && po0 === 1'b1) lat <= cyc - rise_c;
      if (dma === 1'b1) begin
         n_dma <= n_dma + 1;
         gap <= cyc - dma_c;
         dma_c <= cyc;
      end
      if (out1 === prev1) run <= run + 1;
      else begin
         run <= 1;
         if (prev1 === 1'b1) run_hi <= run;
         else run_lo <= run;
      end
   end
   function automatic logic [1:0] exp_resp(input logic [7:0] x);
      return (x[1:0] == 2'h0 && x <= tctu_pkg::OFS_IMASK && x != 8'h28) ? 2'h0 : 2'h2;
   endfunction
   function automatic logic [15:0] exp_wrap(input int ev, input int mx);
      return 16'(ev % mx);
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // holds the request until the answer edge, then lets one edge pass
   task automatic bus(input logic w, input logic [7:0] x, input logic [15:0] d);
      int i;
      i = 0;
      adr <= x;
      wdat <= {16'h0, d};
      rq_rd <= !w;
      rq_wr <= w;
      do begin
         @(posedge ref_clk);
         i++;
      end while (stall !== 1'b0 && i < 20);
      if (stall !== 1'b0) chk("bus answer", 32'h0, 32'h1);
      q = rdat;
      rsp = resp;
      rq_rd <= 1'b0;
      rq_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic results();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      results();
   end
   initial begin
      void'($urandom(69969));
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      bus(1'b0, tctu_pkg::OFS_CTL0, 16'h0);
      chk("ctl0 reset", {16'h0, tctu_pkg::CTL_RST}, q);
      bus(1'b0, tctu_pkg::OFS_MAXB1, 16'h0);
      chk("maxb1 reset", {16'h0, tctu_pkg::MAX_RST}, q);
      foreach (probe[i]) begin
         bus(1'b0, probe[i], 16'h0);
         chk("response", {30'h0, exp_resp(probe[i])}, {30'h0, rsp});
      end
      foreach (rw[i]) begin
         a = $urandom;
         bus(1'b1, rw[i], a[15:0]);
         bus(1'b0, rw[i], 16'h0);
         chk("readback", {16'h0, a[15:0]}, q);
      end
      for (int t = 0; t < 2; t++) begin
         n = 3 + $urandom % 18;
         bus(1'b1, tctu_pkg::OFS_MAXA0 + 8'(16 * t), 16'd1000);
         bus(1'b1, tctu_pkg::OFS_CNT0 + 8'(16 * t), 16'h0);
         bus(1'b1, tctu_pkg::OFS_CTL0 + 8'(16 * t), RUN | EXT);
         u_src.pulses(t, n, 2 + $urandom % 5);
         repeat (10) @(posedge ref_clk);
         bus(1'b0, tctu_pkg::OFS_CNT0 + 8'(16 * t), 16'h0);
         chk("pin event count", {16'h0, exp_wrap(n, 1000)}, q);
      end
      a = 2 + $urandom % 3;
      bus(1'b1, tctu_pkg::OFS_CNT0, 16'h0);
      bus(1'b1, tctu_pkg::OFS_MAXA0, 16'(a));
      base = n_lo0;
      u_src.pulses(0, 2 * a, 3);
      repeat (10) @(posedge ref_clk);
      chk("low cycles", 32'd2, 32'(n_lo0 - base));
      chk("pin to output", 32'h1, {31'h0, lat <= tctu_pkg::RESP_CYC + 1});
      bus(1'b0, tctu_pkg::OFS_CNT0, 16'h0);
      chk("count after wrap", 32'h0, q);
      bus(1'b1, tctu_pkg::OFS_CTL0, 16'h0);
      chk("masked irq", 32'h0, {31'h0, irq});
      bus(1'b1, tctu_pkg::OFS_IMASK, 16'h1 << tctu_pkg::IRQ_TC0);
      repeat (2) @(posedge ref_clk);
      chk("raised irq", 32'h1, {31'h0, irq});
      bus(1'b1, tctu_pkg::OFS_ISTAT, 16'hf);
      repeat (2) @(posedge ref_clk);
      chk("cleared irq", 32'h0, {31'h0, irq});
      h = 2 + $urandom % 4;
      bus(1'b1, tctu_pkg::OFS_MAXA2, 16'(h));
      bus(1'b1, tctu_pkg::OFS_CNT2, 16'h0);
      bus(1'b1, tctu_pkg::OFS_CNT0, 16'h0);
      bus(1'b1, tctu_pkg::OFS_MAXA0, 16'h1000);
      bus(1'b1, tctu_pkg::OFS_CTL0, RUN | PRE);
      base = n_dma;
      bus(1'b1, tctu_pkg::OFS_CTL2, RUN);
      repeat (40 * h) @(posedge ref_clk);
      bus(1'b1, tctu_pkg::OFS_CTL2, 16'h0);
      repeat (8) @(posedge ref_clk);
      chk("wrap spacing", 32'(4 * h), 32'(gap));
      bus(1'b0, tctu_pkg::OFS_CNT0, 16'h0);
      chk("prescaled count", 32'(n_dma - base), q);
      bus(1'b0, tctu_pkg::OFS_CNT2, 16'h0);
      chk("timer two below max", 32'h1, {31'h0, q < 32'(h)});
      a = 2 + $urandom % 8;
      b = 2 + $urandom % 8;
      bus(1'b1, tctu_pkg::OFS_MAXA1, 16'(a));
      bus(1'b1, tctu_pkg::OFS_MAXB1, 16'(b));
      bus(1'b1, tctu_pkg::OFS_CNT1, 16'h0);
      bus(1'b1, tctu_pkg::OFS_CTL1, RUN | ALT);
      repeat (12 * (a + b)) @(posedge ref_clk);
      chk("primary run", 32'(4 * a), 32'(run_hi));
      chk("secondary run", 32'(4 * b), 32'(run_lo));
      bus(1'b1, tctu_pkg::OFS_CTL1, 16'h0);
      bus(1'b1, tctu_pkg::OFS_MAXA1, 16'd40);
      bus(1'b1, tctu_pkg::OFS_ISTAT, 16'hf);
      bus(1'b1, tctu_pkg::OFS_IMASK, 16'h1 << tctu_pkg::IRQ_WDOG);
      bus(1'b1, tctu_pkg::OFS_CTL1, RUN | WDG);
      for (int k = 0; k < 8; k++) begin
         repeat (60) @(posedge ref_clk);
         bus(1'b1, tctu_pkg::OFS_CNT1, 16'h0);
      end
      // a frozen unit must not count: 200 running cycles would wrap at 40
      ce <= 1'b0;
      repeat (200) @(posedge ref_clk);
      ce <= 1'b1;
      repeat (20) @(posedge ref_clk);
      chk("watchdog quiet", 32'h0, {31'h0, irq});
      repeat (200) @(posedge ref_clk);
      chk("watchdog irq", 32'h1, {31'h0, irq});
      // gate open for 20 cycles holds exactly five timer zero slots
      bus(1'b1, tctu_pkg::OFS_CTL0, RUN | GTE);
      bus(1'b1, tctu_pkg::OFS_CNT0, 16'h0);
      u_src.pulses(0, 1, 20);
      bus(1'b0, tctu_pkg::OFS_CNT0, 16'h0);
      chk("gated count", 32'd5, q);
      results();
   end
endmodule
`default_nettype wire
